// *** adist_datapath.sv ***
// The register addresses and register access over Wishbone were decided locally.
`include "adist_regs.svh"
`default_nettype none
module adist_datapath #(
  parameter int RPT_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDat,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Decode side
  input wire logic issue,
  input wire adist_pkg::adist_op_t opSel,
  input wire adist_pkg::adist_idx_t firstAccIdx,
  input wire adist_pkg::adist_idx_t secondAccIdx,
  input wire logic [RPT_W-1:0] rptCount,
  // Data memory read buses
  input wire logic [15:0] xData,
  input wire logic [15:0] yData,
  // Status
  output logic busy,
  output logic carry,
  output logic [3:0] accOverflowFlags
);
  import adist_pkg::*;

  // Elaboration check on the repeat counter
  if (RPT_W < 1 || RPT_W > 16) begin : g_chk
    $error("RPT_W out of range");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Overflow of an exact 41-bit result
  function automatic logic ovfOf(input logic [40:0] v, input logic wide);
    ovfOf = wide ? (v[40] ^ v[`ADIST_WIDE_SIGN]) :
      !((&v[40:`ADIST_NARROW_SIGN]) || !(|v[40:`ADIST_NARROW_SIGN]));
  endfunction

  // Saturation value by result sign
  function automatic adist_acc_t satOf(input logic neg, input logic wide);
    if (wide) satOf = neg ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF;
    else satOf = neg ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF;
  endfunction

  // Operand extension to 40 bits
  function automatic adist_acc_t extOf(input logic [15:0] d, input logic sxm);
    extOf = {{24{sxm & d[15]}}, d};
  endfunction

  // Borrow out at the chosen width
  function automatic logic borrowOf(input adist_acc_t a, input adist_acc_t b,
      input logic bin, input logic wide);
    logic [40:0] w;
    logic [32:0] n;
    w = {1'b0, a} - {1'b0, b} - {40'h00_0000_0000, bin};
    n = {1'b0, a[31:0]} - {1'b0, b[31:0]} - {32'h0000_0000, bin};
    borrowOf = wide ? w[40] : n[32];
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [4:0] ctrl_r; // Mode bits
  logic carry_r; // Carry flag
  logic [3:0] ovf_r; // Accumulator overflow flags
  logic busy_r; // Repeat in progress
  logic ack_r; // Bus acknowledge
  logic [31:0] rdat_r; // Bus read data
  adist_state_t state_r; // Repeat sequencer
  adist_state_t stateNxt;
  logic [RPT_W-1:0] rptLeft_r; // Iterations still to run
  adist_op_t op_r; // Latched operation
  adist_idx_t xIdx_r; // Latched first accumulator
  adist_idx_t yIdx_r; // Latched second accumulator

  adist_acc_if acc();
  adist_acc_file u_accs (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .acc(acc)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  wire modeWide = ctrl_r[`ADIST_CTRL_WIDE];
  wire modeSxm = ctrl_r[`ADIST_CTRL_SXM];
  wire modeSat = ctrl_r[`ADIST_CTRL_SAT];
  wire modeLegacy = ctrl_r[`ADIST_CTRL_LEGACY];

  // Issue taken only when idle; a repeat runs with latched operation and accumulator indices
  wire idle = (state_r == ADIST_ST_IDLE);
  wire exec = (idle && issue) || !idle;
  wire adist_op_t curOp = idle ? opSel : op_r;
  wire adist_idx_t curX = idle ? firstAccIdx : xIdx_r;
  wire adist_idx_t curY = idle ? secondAccIdx : yIdx_r;
  wire isAbdst = (curOp == ADIST_OP_ABDST);

  // Pre-instruction contents feed both paths
  wire adist_acc_t accFirst = acc.rdAcc[curX];
  wire adist_acc_t accSecond = acc.rdAcc[curY];

  // ----------------------------------------
  // Absolute-value accumulation
  // ----------------------------------------
  wire [15:0] hiPart = accFirst[31:16];
  wire [16:0] absMag = hiPart[15] ? (17'h0_0000 - {1'b1, hiPart}) : {1'b0, hiPart};
  wire adist_acc_t absAddend = {7'h00, absMag, 16'h0000};
  wire [40:0] sumExact = {accSecond[39], accSecond} + {1'b0, absAddend};
  wire sumOvf = ovfOf(sumExact, modeWide);
  wire adist_acc_t sumRes = (sumOvf && modeSat) ?
    satOf(sumExact[40], modeWide) : sumExact[39:0];

  // ----------------------------------------
  // Subtraction
  // ----------------------------------------
  // Both memory operands shifted into the high part
  wire adist_acc_t xExt = extOf(xData, modeSxm);
  wire adist_acc_t yExt = extOf(yData, modeSxm);
  wire adist_acc_t xShift = xExt << `ADIST_OPND_SHIFT;
  wire adist_acc_t yShift = yExt << `ADIST_OPND_SHIFT;
  // Borrow form: zero-extended operand and inverted carry
  wire subBin = isAbdst ? 1'b0 : !carry_r;
  wire adist_acc_t subA = isAbdst ? xShift : accFirst;
  wire adist_acc_t subB = isAbdst ? yShift : extOf(xData, 1'b0);
  wire [40:0] diffExact = {subA[39], subA} - {subB[39], subB} -
    {40'h00_0000_0000, subBin};
  // Legacy mode drops all checks on the shifted subtraction
  wire subChecked = !(isAbdst && modeLegacy);
  wire subOvf = subChecked && ovfOf(diffExact, modeWide);
  wire adist_acc_t subRes = (subOvf && modeSat) ?
    satOf(diffExact[40], modeWide) : diffExact[39:0];
  wire subBorrow = borrowOf(subA, subB, subBin, modeWide);
  wire adist_idx_t subDst = isAbdst ? curX : curY;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire busReq = wbCyc && wbStb;
  wire busWr = busReq && wbWe && ack_r;
  wire adrCtrl = (wbAdr == `ADIST_CTRL_OFS);
  wire adrStat = (wbAdr == `ADIST_STAT_OFS);
  wire adrAccLo = (wbAdr[7:4] == `ADIST_ACCLO_OFS >> 4);
  wire adrAccHi = (wbAdr[7:4] == `ADIST_ACCHI_OFS >> 4);
  wire adist_idx_t busIdx = wbAdr[3:2];
  wire [31:0] byteMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};
  wire adist_acc_t busAcc = acc.rdAcc[busIdx];
  wire [31:0] loMerged = (busAcc[31:0] & ~byteMask) | (wbDat & byteMask);
  wire [31:0] statWord = {24'h00_0000, ovf_r, 2'b00, busy_r, carry_r};
  wire [31:0] readMux = adrCtrl ? {27'h000_0000, ctrl_r} :
    adrStat ? statWord :
    adrAccLo ? busAcc[31:0] :
    adrAccHi ? {24'h00_0000, busAcc[39:32]} : 32'h0000_0000;
  // Software loads accumulators only while no operation runs
  wire busAccWr = busWr && !exec && (adrAccLo || adrAccHi);

  // ----------------------------------------
  // Accumulator writes
  // ----------------------------------------
  // Sum on port A, subtraction on port B, one edge for both
  assign acc.wrEnA = (exec && isAbdst) || busAccWr;
  assign acc.wrIdxA = exec ? curY : busIdx;
  assign acc.wrDataA = exec ? sumRes :
    adrAccLo ? {busAcc[39:32], loMerged} :
    {(wbSel[0] ? wbDat[7:0] : busAcc[39:32]), busAcc[31:0]};
  assign acc.wrEnB = exec;
  assign acc.wrIdxB = subDst;
  assign acc.wrDataB = subRes;

  // ----------------------------------------
  // Repeat sequencer
  // ----------------------------------------
  always_comb begin
    stateNxt = state_r;
    unique case (state_r)
      ADIST_ST_IDLE: if (issue && rptCount != '0) stateNxt = ADIST_ST_RPT;
      ADIST_ST_RPT: if (rptLeft_r == RPT_W'(1)) stateNxt = ADIST_ST_IDLE;
      default: stateNxt = ADIST_ST_IDLE;
    endcase
  end

  // Each iteration is a full execution; only the count differs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ADIST_ST_IDLE;
      rptLeft_r <= '0;
      op_r <= ADIST_OP_ABDST;
      xIdx_r <= 2'h0;
      yIdx_r <= 2'h0;
      busy_r <= 1'b0;
    end else begin
      state_r <= stateNxt;
      busy_r <= (stateNxt == ADIST_ST_RPT);
      if (idle && issue) begin
        rptLeft_r <= rptCount;
        op_r <= opSel;
        xIdx_r <= firstAccIdx;
        yIdx_r <= secondAccIdx;
      end else if (!idle) begin
        rptLeft_r <= rptLeft_r - RPT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Flags and mode register
  // ----------------------------------------
  // Hardware set wins over software clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_r <= `ADIST_CTRL_RST;
      carry_r <= `ADIST_CARRY_RST;
      ovf_r <= 4'h0;
    end else begin
      if (busWr && adrCtrl && wbSel[0]) ctrl_r <= wbDat[4:0];
      for (int i = 0; i < 4; i++) begin
        if (exec && ((isAbdst && sumOvf && curY == 2'(i)) ||
            (subOvf && subDst == 2'(i)))) begin
          ovf_r[i] <= 1'b1;
        end else if (busWr && adrStat && wbSel[0] && wbDat[`ADIST_STAT_OVF + i]) begin
          ovf_r[i] <= 1'b0;
        end
      end
      if (exec && subChecked) carry_r <= !subBorrow;
      else if (busWr && adrStat && wbSel[0]) carry_r <= wbDat[`ADIST_STAT_CARRY];
    end
  end

  // ----------------------------------------
  // Wishbone answer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= busReq && !ack_r;
      if (busReq && !ack_r) rdat_r <= readMux;
    end
  end

  assign wbAck = ack_r;
  assign wbDatOut = rdat_r;
  assign busy = busy_r;
  assign carry = carry_r;
  assign accOverflowFlags = ovf_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire quiet = !(busReq && wbWe);
  wire plainSub = exec && isAbdst && curX != curY && quiet;

  property p_sub_zero;
    plainSub && !modeSxm && !modeSat |=> acc.rdAcc[$past(curX)] ==
      ({8'h00, $past(xData), 16'h0000} - {8'h00, $past(yData), 16'h0000});
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("shifted subtract wrong");

  property p_sign_ext;
    plainSub && modeSxm && modeLegacy |=> acc.rdAcc[$past(curX)] ==
      ({{8{$past(xData[15])}}, $past(xData), 16'h0000} -
       {{8{$past(yData[15])}}, $past(yData), 16'h0000});
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

  property p_abs_sat;
    plainSub && modeSat && modeWide && accSecond == 40'h7F_FFFF_FFFF &&
      accFirst[31:16] != 16'h0000 |=>
      acc.rdAcc[$past(curY)] == 40'h7F_FFFF_FFFF && ovf_r[$past(curY)];
  endproperty
  a_abs_sat: assert property (p_abs_sat) else $error("absolute sum not saturated");

  property p_sub_sat;
    plainSub && modeSat && !modeWide && !modeSxm && !modeLegacy &&
      xData == 16'h0000 && yData == 16'h8001 |=>
      acc.rdAcc[$past(curX)] == 40'hFF_8000_0000 && ovf_r[$past(curX)];
  endproperty
  a_sub_sat: assert property (p_sub_sat) else $error("subtract not saturated");

  property p_carry;
    plainSub && !modeSxm && !modeLegacy |=> carry_r == ($past(xData) >= $past(yData));
  endproperty
  a_carry: assert property (p_carry) else $error("carry not inverted borrow");

  property p_legacy;
    plainSub && modeLegacy && !ovf_r[curX] |=> carry_r == $past(carry_r) && !ovf_r[$past(curX)];
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy subtract reported flags");

  sequence s_rpt_run;
    busy_r [*3] ##1 !busy_r;
  endsequence
  property p_repeat;
    idle && issue && rptCount == RPT_W'(3) |=> s_rpt_run;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat length wrong");

  property p_subb;
    exec && !isAbdst && !modeWide && !modeSat && quiet |=> acc.rdAcc[$past(curY)] ==
      $past(accFirst) - {24'h00_0000, $past(xData)} - {39'h00_0000_0000, !$past(carry_r)};
  endproperty
  a_subb: assert property (p_subb) else $error("subtract with borrow wrong");

  property p_narrow_pos;
    plainSub && modeSat && !modeWide && accSecond == 40'h00_7FFF_0000 &&
      accFirst[31:16] == 16'h0001 |=> acc.rdAcc[$past(curY)] == 40'h00_7FFF_FFFF;
  endproperty
  a_narrow_pos: assert property (p_narrow_pos) else $error("bit 31 overflow missed");
endmodule
`default_nettype wire

// *** adist_regs.svh ***
// Behaviour
// - one instruction, two parallel accumulator operations
// - subtract shifted second operand from shifted first
// - operands extended to 40 bits, signed or zero
// - absolute sum overflow sets flag, may saturate
// - subtraction overflow sets flag, may saturate
// - carry holds inverted borrow, position per width
// - legacy mode skips shifted subtraction overflow, flags, saturation
// - repeated iterations behave like single executions
// - subtract-with-borrow uses zero-extended operand, inverted carry
// - sign and overflow at bit 31 or 39
`ifndef ADIST_REGS_SVH
`define ADIST_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADIST_CTRL_OFS 8'h00
`define ADIST_STAT_OFS 8'h04
`define ADIST_ACCLO_OFS 8'h10
`define ADIST_ACCHI_OFS 8'h20

// ----------------------------------------
// Control fields
// ----------------------------------------
`define ADIST_CTRL_WIDE 0
`define ADIST_CTRL_SXM 1
`define ADIST_CTRL_SAT 2
`define ADIST_CTRL_LEGACY 3
`define ADIST_CTRL_FRACT 4
`define ADIST_CTRL_RST 5'h00

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ADIST_STAT_CARRY 0
`define ADIST_STAT_BUSY 1
`define ADIST_STAT_OVF 4
`define ADIST_CARRY_RST 1'h0

// ----------------------------------------
// Datapath constants
// ----------------------------------------
`define ADIST_OPND_SHIFT 16
`define ADIST_NARROW_SIGN 31
`define ADIST_WIDE_SIGN 39

`endif

// *** adist_pkg.sv ***
`default_nettype none
package adist_pkg;
  // Accumulator word
  typedef logic [39:0] adist_acc_t;
  // Accumulator index
  typedef logic [1:0] adist_idx_t;
  // Operations issued by decode
  typedef enum logic [1:0] {
    ADIST_OP_ABDST = 2'b01,
    ADIST_OP_SUBB = 2'b10
  } adist_op_t;
  // Repeat sequencer states
  typedef enum logic [1:0] {
    ADIST_ST_IDLE = 2'b01,
    ADIST_ST_RPT = 2'b10
  } adist_state_t;
endpackage
`default_nettype wire

// *** adist_acc_if.sv ***
`default_nettype none
interface adist_acc_if;
  import adist_pkg::*;
  // Port A write
  logic wrEnA;
  adist_idx_t wrIdxA;
  adist_acc_t wrDataA;
  // Port B write, wins over A on same index
  logic wrEnB;
  adist_idx_t wrIdxB;
  adist_acc_t wrDataB;
  // Current accumulator contents
  adist_acc_t rdAcc [4];
  modport ctrl (output wrEnA, wrIdxA, wrDataA, wrEnB, wrIdxB, wrDataB, input rdAcc);
  modport store (input wrEnA, wrIdxA, wrDataA, wrEnB, wrIdxB, wrDataB, output rdAcc);
endinterface
`default_nettype wire

// *** adist_acc_file.sv ***
`default_nettype none
module adist_acc_file (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Accumulator access
  adist_acc_if.store acc
);
  import adist_pkg::*;

  // Four accumulators
  adist_acc_t acc_r [4];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Both ports land on the same edge
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n) begin
        acc_r[i] <= 40'h00_0000_0000;
      end else if (acc.wrEnB && acc.wrIdxB == 2'(i)) begin
        acc_r[i] <= acc.wrDataB;
      end else if (acc.wrEnA && acc.wrIdxA == 2'(i)) begin
        acc_r[i] <= acc.wrDataA;
      end
    end
  end

  // Contents straight from the flops
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      acc.rdAcc[i] = acc_r[i];
    end
  end
endmodule
`default_nettype wire

// *** adist_decode_model.sv ***
`default_nettype none
// ----------------------------------------
// Decode stage and memory bus model
// ----------------------------------------
module adist_decode_model #(
  parameter int RPT_W = 4
) (
  // Clock
  input wire logic clk_sys,
  // Issue side
  output logic issue,
  output adist_pkg::adist_op_t opSel,
  output adist_pkg::adist_idx_t firstAccIdx,
  output adist_pkg::adist_idx_t secondAccIdx,
  output logic [RPT_W-1:0] rptCount,
  // Memory operands
  output logic [15:0] xData,
  output logic [15:0] yData,
  // Repeat status
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  import adist_pkg::*;

  // Quiet decode until the bench asks for an operation
  initial begin
    issue = 1'b0;
    opSel = ADIST_OP_ABDST;
    firstAccIdx = 2'h0;
    secondAccIdx = 2'h0;
    rptCount = '0;
    xData = 16'hA5A5;
    yData = 16'h5A5A;
  end

  // One issue pulse, then fresh operands for every repeated pass
  task automatic runOp(input adist_op_t op, input adist_idx_t f, input adist_idx_t s,
      input int n, input logic [15:0] xs [3], input logic [15:0] ys [3], output int nb);
    nb = 0;
    @(posedge clk_sys);
    issue <= 1'b1;
    opSel <= op;
    firstAccIdx <= f;
    secondAccIdx <= s;
    rptCount <= RPT_W'(n);
    xData <= xs[0];
    yData <= ys[0];
    // Buses go stale (inverted) once the last pass has read them
    for (int k = 1; k <= n + 1; k++) begin
      @(posedge clk_sys);
      nb += int'(busy === 1'b1);
      issue <= 1'b0;
      xData <= (k <= n) ? xs[k] : ~xs[n];
      yData <= (k <= n) ? ys[k] : ~ys[n];
    end
    @(posedge clk_sys);
    nb += int'(busy === 1'b1);
  endtask
endmodule
`default_nettype wire

// *** adist_datapath_test.sv ***
`include "adist_regs.svh"
`default_nettype none
module adist_datapath_test;
  timeunit 1ns;
  timeprecision 1ns;
  import adist_pkg::*;
  // ----------------------------------------
  // Settings and tables
  // ----------------------------------------
  localparam int RPT_W = 4;
  localparam logic [4:0] WIDE = 5'h01;
  localparam logic [4:0] SXM = 5'h02;
  localparam logic [4:0] SAT = 5'h04;
  localparam logic [4:0] LEG = 5'h08;
  // Absolute path cases: mode, sum, flags
  localparam logic [4:0] ABS_MODE [3] = '{SAT, 5'h00, WIDE | SAT};
  localparam logic [39:0] ABS_SUM [3] = '{40'h00_7FFF_FFFF, 40'h00_FFFF_0000, 40'h00_FFFF_0000};
  localparam logic [3:0] ABS_OVF [3] = '{4'h2, 4'h2, 4'h0};
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h0000_0000;
  logic [31:0] wbDatOut;
  logic wbAck;
  logic issue;
  adist_op_t opSel;
  adist_idx_t firstAccIdx;
  adist_idx_t secondAccIdx;
  logic [RPT_W-1:0] rptCount;
  logic [15:0] xData;
  logic [15:0] yData;
  logic busy;
  logic carry;
  logic [3:0] accOverflowFlags;
  int nErrors = 0;
  int comparisons = 0;
  int cycles = 0;

  adist_datapath #(.RPT_W(RPT_W)) i_adist_datapath (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDat(wbDat), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .issue(issue), .opSel(opSel), .firstAccIdx(firstAccIdx),
    .secondAccIdx(secondAccIdx), .rptCount(rptCount), .xData(xData), .yData(yData),
    .busy(busy), .carry(carry), .accOverflowFlags(accOverflowFlags)
  );

  adist_decode_model #(.RPT_W(RPT_W)) i_adist_decode_model (
    .clk_sys(clk_sys), .issue(issue), .opSel(opSel), .firstAccIdx(firstAccIdx),
    .secondAccIdx(secondAccIdx), .rptCount(rptCount), .xData(xData), .yData(yData),
    .busy(busy)
  );

  // 50 ns clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Hang guard, far beyond the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
      input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDat <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    // Missing ack counts as a mismatch
    if (wbAck !== 1'b1) begin
      nErrors++;
    end
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wbWrite(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    logic [31:0] unused;
    wbCycle(1'b1, adr, sel, dat, unused);
  endtask

  task automatic setAcc(input int n, input logic [39:0] v);
    wbWrite(8'(`ADIST_ACCLO_OFS + 4 * n), 4'hF, v[31:0]);
    wbWrite(8'(`ADIST_ACCHI_OFS + 4 * n), 4'h1, {24'h00_0000, v[39:32]});
  endtask

  task automatic checkAcc(input string what, input int n, input logic [39:0] exp);
    logic [31:0] lo;
    logic [31:0] hi;
    wbCycle(1'b0, 8'(`ADIST_ACCLO_OFS + 4 * n), 4'hF, 32'h0000_0000, lo);
    wbCycle(1'b0, 8'(`ADIST_ACCHI_OFS + 4 * n), 4'hF, 32'h0000_0000, hi);
    check(what, {hi[7:0], lo}, exp);
  endtask

  // Issue through the decode model and count busy cycles
  task automatic run(input adist_op_t op, input adist_idx_t f, input adist_idx_t s,
      input int n, input logic [15:0] xs [3], input logic [15:0] ys [3]);
    int nb;
    i_adist_decode_model.runOp(op, f, s, n, xs, ys, nb);
    check("busy cycles", 40'(nb), 40'(n));
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // Reset state and an unmapped read
    wbCycle(1'b0, `ADIST_STAT_OFS, 4'hF, 32'h0000_0000, rd);
    check("status after reset", 40'(rd), 40'h0);
    wbCycle(1'b0, 8'h3C, 4'hF, 32'h0000_0000, rd);
    check("unmapped read", 40'(rd), 40'h0);
    // Plain absolute distance, wide signed, borrow
    wbWrite(`ADIST_CTRL_OFS, 4'hF, {27'h000_0000, WIDE | SXM});
    setAcc(1, 40'h00_E800_0000);
    run(ADIST_OP_ABDST, 2'h0, 2'h1, 0, '{16'h3400, 16'h0000, 16'h0000},
        '{16'hEF00, 16'h0000, 16'h0000});
    checkAcc("difference", 0, 40'h00_4500_0000);
    checkAcc("sum", 1, 40'h00_E800_0000);
    check("carry", 40'(carry), 40'h0);
    // Absolute sum overflow per width and saturation
    for (int i = 0; i < 3; i++) begin
      wbWrite(`ADIST_CTRL_OFS, 4'hF, {27'h000_0000, ABS_MODE[i]});
      wbWrite(`ADIST_STAT_OFS, 4'hF, 32'h0000_00F0);
      setAcc(0, 40'h00_8000_0000);
      setAcc(1, 40'h00_7FFF_0000);
      run(ADIST_OP_ABDST, 2'h0, 2'h1, 0, '{16'h0001, 16'h0000, 16'h0000},
          '{16'h0000, 16'h0000, 16'h0000});
      checkAcc("abs sum", 1, ABS_SUM[i]);
      check("abs flags", 40'(accOverflowFlags), 40'(ABS_OVF[i]));
      checkAcc("difference", 0, 40'h00_0001_0000);
      check("carry", 40'(carry), 40'h1);
    end
    // Subtraction overflow, then the same under legacy mode
    for (int lg = 0; lg < 2; lg++) begin
      wbWrite(`ADIST_CTRL_OFS, 4'hF, {27'h000_0000, SXM | SAT | (lg != 0 ? LEG : 5'h00)});
      wbWrite(`ADIST_STAT_OFS, 4'hF, 32'h0000_00F1);
      setAcc(0, 40'h00_0000_0000);
      // Empty second accumulator keeps the absolute sum clear of overflow
      setAcc(1, 40'h00_0000_0000);
      run(ADIST_OP_ABDST, 2'h0, 2'h1, 0, '{16'h7FFF, 16'h0000, 16'h0000},
          '{16'h8000, 16'h0000, 16'h0000});
      checkAcc("sub result", 0, lg != 0 ? 40'h00_FFFF_0000 : 40'h00_7FFF_FFFF);
      check("sub flags", 40'(accOverflowFlags), lg != 0 ? 40'h0 : 40'h1);
      check("carry", 40'(carry), lg != 0 ? 40'h1 : 40'h0);
    end
    // Zero extension of operands
    wbWrite(`ADIST_CTRL_OFS, 4'hF, {27'h000_0000, WIDE});
    run(ADIST_OP_ABDST, 2'h0, 2'h1, 0, '{16'h0000, 16'h0000, 16'h0000},
        '{16'h8000, 16'h0000, 16'h0000});
    checkAcc("zero extended", 0, 40'hFF_8000_0000);
    check("carry", 40'(carry), 40'h0);
    // Three passes under repeat, new operands each pass
    wbWrite(`ADIST_CTRL_OFS, 4'hF, 32'h0000_0000);
    wbWrite(`ADIST_STAT_OFS, 4'hF, 32'h0000_00F0);
    setAcc(0, 40'h00_0003_0000);
    setAcc(1, 40'h00_0000_0000);
    run(ADIST_OP_ABDST, 2'h0, 2'h1, 2, '{16'h0005, 16'h0001, 16'h0000},
        '{16'h0001, 16'h0003, 16'h0000});
    checkAcc("repeat difference", 0, 40'h00_0000_0000);
    checkAcc("repeat sum", 1, 40'h00_0009_0000);
    check("repeat flags", 40'(accOverflowFlags), 40'h0);
    check("carry", 40'(carry), 40'h1);
    // Subtract with borrow, both carry inputs
    wbWrite(`ADIST_CTRL_OFS, 4'hF, {27'h000_0000, WIDE | SXM});
    setAcc(2, 40'h00_0000_0010);
    for (int i = 0; i < 2; i++) begin
      wbWrite(`ADIST_STAT_OFS, 4'hF, 32'(i));
      run(ADIST_OP_SUBB, 2'h2, 2'h3, 0, '{i != 0 ? 16'h0005 : 16'hFFFF, 16'h0000, 16'h0000},
          '{16'h1234, 16'h0000, 16'h0000});
      checkAcc("borrow sub", 3, i != 0 ? 40'h00_0000_000B : 40'hFF_FFFF_0010);
      check("carry", 40'(carry), 40'(i));
    end
    checkAcc("source kept", 2, 40'h00_0000_0010);
    end_of_test();
  end
endmodule
`default_nettype wire
